// ---- hw/ddr4_core_pkg.sv ----
// Purpose: Shared constants, types and helpers for the DRAM access core.
// Assumes: One command per clock at most; two data beats per clock at the pins.
// Notes: Beat columns wrap inside an aligned group of eight; upper column bits come from the command.
package ddr4_core_pkg;

  localparam int ADDR_BITS = 18;
  localparam int ROW_BITS = 16;
  localparam int COL_BITS = 10;
  localparam int BANK_IDX_BITS = 4;
  localparam int MAX_BANKS = 16;
  localparam int BANKS_PER_GROUP = 4;
  localparam int X8_GROUPS = 4;
  localparam int X16_GROUPS = 2;
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  localparam logic [1:0] BL8_LAST = 2'h3;
  localparam logic [1:0] BC4_LAST = 2'h1;
  localparam logic [1:0] PAIR_FIRST = 2'h0;

  // Burst length modes as held by the mode setting.
  localparam logic [1:0] BURST_BL8 = 2'h0;
  localparam logic [1:0] BURST_OTF = 2'h1;
  localparam logic [1:0] BURST_BC4 = 2'h2;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_ACT = 3'h1,
    CMD_RD = 3'h2,
    CMD_WR = 3'h3,
    CMD_PRE = 3'h4
  } cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_READ = 3'h2,
    ST_WRITE = 3'h4
  } state_t;

  // Column low bits of a beat; sequential wraps inside the nibble, interleave is an XOR.
  function automatic logic [2:0] beatCol(input logic [2:0] s, input logic [2:0] i, input logic ilv);
    logic [1:0] low;
    low = s[1:0] + i[1:0];
    return ilv ? (s ^ i) : {s[2] ^ i[2], low};
  endfunction

endpackage

// ---- hw/burst_if.sv ----
// Purpose: Carries burst start and beat ordering between controller and sequencer.
// Assumes: Single clock domain.
// Notes: Start is a one-cycle pulse; the rest are levels.
`timescale 1ns/1ps
interface burst_if;
  logic start;
  logic bc4;
  logic interleave;
  logic [2:0] startLo;
  logic active;
  logic last;
  logic [2:0] colRise;
  logic [2:0] colFall;

  modport seq (input start, input bc4, input interleave, input startLo,
               output active, output last, output colRise, output colFall);
  modport ctl (output start, output bc4, output interleave, output startLo,
               input active, input last, input colRise, input colFall);
endinterface

// ---- hw/burst_seq.sv ----
// Purpose: Walks the beat pairs of one burst and orders their columns.
// Assumes: Start only arrives while no burst is active.
// Notes: One pair of beats per clock, so eight beats take four clocks.
`timescale 1ns/1ps
module burst_seq (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic dramResetN,
  burst_if.seq bus
);
  import ddr4_core_pkg::*;

  logic activeReg, activeNext;
  logic bc4Reg, bc4Next;
  logic ilvReg, ilvNext;
  logic [1:0] pairReg, pairNext;
  logic [2:0] startReg, startNext;

  // Beat columns for the rising and falling half of the current clock.
  assign bus.active = activeReg;
  assign bus.last = activeReg && (pairReg == (bc4Reg ? BC4_LAST : BL8_LAST));
  assign bus.colRise = beatCol(startReg, {pairReg, 1'b0}, ilvReg);
  assign bus.colFall = beatCol(startReg, {pairReg, 1'b1}, ilvReg);

  // Start latches the burst shape; the last pair ends it.
  always_comb begin
    activeNext = activeReg;
    bc4Next = bc4Reg;
    ilvNext = ilvReg;
    pairNext = pairReg;
    startNext = startReg;
    if (bus.start) begin
      activeNext = 1'b1;
      pairNext = PAIR_FIRST;
      bc4Next = bus.bc4;
      ilvNext = bus.interleave;
      startNext = bus.startLo;
    end else if (bus.last) begin
      activeNext = 1'b0;
      pairNext = PAIR_FIRST;
    end else if (activeReg) begin
      pairNext = pairReg + 2'h1;
    end
  end

  // The array reset acts at once, without waiting for the clock.
  always_ff @(posedge mclk or negedge dramResetN) begin
    if (!dramResetN) begin
      activeReg <= 1'b0;
      bc4Reg <= 1'b0;
      ilvReg <= 1'b0;
      pairReg <= PAIR_FIRST;
      startReg <= 3'h0;
    end else if (sys_rst) begin
      activeReg <= 1'b0;
      bc4Reg <= 1'b0;
      ilvReg <= 1'b0;
      pairReg <= PAIR_FIRST;
      startReg <= 3'h0;
    end else begin
      activeReg <= activeNext;
      bc4Reg <= bc4Next;
      ilvReg <= ilvNext;
      pairReg <= pairNext;
      startReg <= startNext;
    end
  end

  AST_BURST_LEN: assert property (@(posedge mclk) disable iff (sys_rst || !dramResetN)
    bus.start && !bus.bc4 |=> bus.active[*3] ##1 bus.last ##1 !bus.active)
    else $error("Full burst did not last four clocks.");
endmodule // burst_seq

// ---- hw/ddr4_core.sv ----
// Purpose: Bank, row and burst datapath of the DRAM device behind its command pins.
// Assumes: Commands arrive synchronous to mclk; data pins carry a rising and a falling beat per clock.
// Notes: Only the low ROW_KEEP row bits index the storage, so simulation memory stays small.
`timescale 1ns/1ps
module ddr4_core #(
  parameter int DQ_WIDTH = 8,
  parameter int ROW_KEEP = 2
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic dramResetN,
  input wire logic cmdValid,
  input wire ddr4_core_pkg::cmd_t cmdCode,
  input wire logic [1:0] bankGroup,
  input wire logic [1:0] bankAddr,
  input wire logic [ddr4_core_pkg::ADDR_BITS-1:0] addr,
  input wire logic [1:0] modeBurst,
  input wire logic modeInterleave,
  input wire logic [DQ_WIDTH-1:0] dqInRise,
  input wire logic [DQ_WIDTH-1:0] dqInFall,
  output logic cmdReady,
  output logic cmdErr,
  output logic [DQ_WIDTH-1:0] dqRise,
  output logic [DQ_WIDTH-1:0] dqFall,
  output logic dqOeN,
  output logic [ddr4_core_pkg::MAX_BANKS-1:0] bankOpen
);
  import ddr4_core_pkg::*;

  localparam int NUM_BG = (DQ_WIDTH == 16) ? X16_GROUPS : X8_GROUPS;
  localparam int NUM_BANKS = NUM_BG * BANKS_PER_GROUP;
  localparam int MEM_BITS = BANK_IDX_BITS + ROW_KEEP + COL_BITS;

  // The x16 part has only one group bit, so the upper one is ignored.
  function automatic logic [BANK_IDX_BITS-1:0] bankIdx(input logic [1:0] bg, input logic [1:0] ba);
    logic [1:0] g;
    g = (NUM_BG == X16_GROUPS) ? {1'b0, bg[0]} : bg;
    return {g, ba};
  endfunction

  // Storage index of one beat inside the open row of the burst bank.
  function automatic logic [MEM_BITS-1:0] memAddr(input logic [BANK_IDX_BITS-1:0] b,
                                                   input logic [ROW_BITS-1:0] r,
                                                   input logic [COL_BITS-1:0] c,
                                                   input logic [2:0] lo);
    return {b, r[ROW_KEEP-1:0], c[COL_BITS-1:3], lo};
  endfunction

  state_t stateReg, stateNext;
  logic [MAX_BANKS-1:0] openReg, openNext;
  logic [ROW_BITS-1:0] rowReg [MAX_BANKS];
  logic [ROW_BITS-1:0] rowNext [MAX_BANKS];
  logic [BANK_IDX_BITS-1:0] curBankReg, curBankNext;
  logic [COL_BITS-1:0] colReg, colNext;
  logic autoPreReg, autoPreNext;
  logic cmdErrReg, cmdErrNext;
  logic [DQ_WIDTH-1:0] dqRiseReg, dqRiseNext;
  logic [DQ_WIDTH-1:0] dqFallReg, dqFallNext;
  logic dqOeNReg, dqOeNNext;
  logic [DQ_WIDTH-1:0] mem [2**MEM_BITS];
  logic idle;
  logic accept;
  logic rwGo;
  logic bc4Sel;
  logic [BANK_IDX_BITS-1:0] reqIdx;
  logic [ROW_BITS-1:0] curRow;

  burst_if seqBus ();

  burst_seq u_seq (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .dramResetN(dramResetN),
    .bus(seqBus)
  );

  // Commands are taken only between bursts, while cmdReady is high; others are dropped, and a non-NOP one raises cmdErr.
  assign idle = (stateReg == ST_IDLE);
  assign cmdReady = idle;
  assign accept = cmdValid && idle;
  assign reqIdx = bankIdx(bankGroup, bankAddr);
  assign rwGo = accept && (cmdCode == CMD_RD || cmdCode == CMD_WR) && openReg[reqIdx];
  assign bc4Sel = (modeBurst == BURST_BC4) || (modeBurst == BURST_OTF && !addr[BC_BIT]);
  assign curRow = rowReg[curBankReg];

  // Burst shape handed to the sequencer on the accepting edge.
  assign seqBus.start = rwGo;
  assign seqBus.bc4 = bc4Sel;
  assign seqBus.interleave = modeInterleave;
  assign seqBus.startLo = addr[2:0];

  assign cmdErr = cmdErrReg;
  assign dqRise = dqRiseReg;
  assign dqFall = dqFallReg;
  assign dqOeN = dqOeNReg;
  assign bankOpen = openReg;

  // Command decode and bank bookkeeping.
  always_comb begin
    stateNext = stateReg;
    openNext = openReg;
    rowNext = rowReg;
    curBankNext = curBankReg;
    colNext = colReg;
    autoPreNext = autoPreReg;
    cmdErrNext = 1'b0;
    if (cmdValid && !idle && cmdCode != CMD_NOP) begin
      cmdErrNext = 1'b1;
    end
    if (accept) begin
      case (cmdCode)
        CMD_ACT: begin
          if (openReg[reqIdx]) begin
            cmdErrNext = 1'b1;
          end else begin
            openNext[reqIdx] = 1'b1;
            rowNext[reqIdx] = addr[ROW_BITS-1:0];
          end
        end
        CMD_PRE: begin
          if (addr[AP_BIT]) begin
            openNext = '0;
          end else begin
            openNext[reqIdx] = 1'b0;
          end
        end
        CMD_RD, CMD_WR: begin
          if (!openReg[reqIdx]) begin
            cmdErrNext = 1'b1;
          end else begin
            stateNext = (cmdCode == CMD_RD) ? ST_READ : ST_WRITE;
            curBankNext = reqIdx;
            colNext = addr[COL_BITS-1:0];
            autoPreNext = addr[AP_BIT];
          end
        end
        default: begin
        end
      endcase
    end
    // Closing at the last pair lets the next activate follow the burst directly.
    if (!idle && seqBus.last) begin
      stateNext = ST_IDLE;
      if (autoPreReg) begin
        openNext[curBankReg] = 1'b0;
      end
    end
  end

  // Read beats are registered, so the pins lag the internal pair by one clock.
  always_comb begin
    dqRiseNext = '0;
    dqFallNext = '0;
    dqOeNNext = 1'b1;
    if (stateReg == ST_READ) begin
      dqRiseNext = mem[memAddr(curBankReg, curRow, colReg, seqBus.colRise)];
      dqFallNext = mem[memAddr(curBankReg, curRow, colReg, seqBus.colFall)];
      dqOeNNext = 1'b0;
    end
  end

  // Write beats land two per clock; the array has no reset on purpose.
  always_ff @(posedge mclk) begin
    if (stateReg == ST_WRITE && !sys_rst && dramResetN) begin
      mem[memAddr(curBankReg, curRow, colReg, seqBus.colRise)] <= dqInRise;
      mem[memAddr(curBankReg, curRow, colReg, seqBus.colFall)] <= dqInFall;
    end
  end

  // Control state; the array reset pin acts asynchronously.
  always_ff @(posedge mclk or negedge dramResetN) begin
    if (!dramResetN) begin
      stateReg <= ST_IDLE;
      openReg <= '0;
      rowReg <= '{default: '0};
      curBankReg <= '0;
      colReg <= '0;
      autoPreReg <= 1'b0;
      cmdErrReg <= 1'b0;
      dqRiseReg <= '0;
      dqFallReg <= '0;
      dqOeNReg <= 1'b1;
    end else if (sys_rst) begin
      stateReg <= ST_IDLE;
      openReg <= '0;
      rowReg <= '{default: '0};
      curBankReg <= '0;
      colReg <= '0;
      autoPreReg <= 1'b0;
      cmdErrReg <= 1'b0;
      dqRiseReg <= '0;
      dqFallReg <= '0;
      dqOeNReg <= 1'b1;
    end else begin
      stateReg <= stateNext;
      openReg <= openNext;
      rowReg <= rowNext;
      curBankReg <= curBankNext;
      colReg <= colNext;
      autoPreReg <= autoPreNext;
      cmdErrReg <= cmdErrNext;
      dqRiseReg <= dqRiseNext;
      dqFallReg <= dqFallNext;
      dqOeNReg <= dqOeNNext;
    end
  end

  AST_RESET_CLEARS: assert property (@(posedge mclk) disable iff (sys_rst)
    !dramResetN |-> openReg == '0 && dqOeN && stateReg == ST_IDLE)
    else $error("State survived a low array reset.");

  AST_BANK_RANGE: assert property (@(posedge mclk) disable iff (sys_rst || !dramResetN)
    (openReg >> NUM_BANKS) == '0)
    else $error("Bank beyond the organised count is open.");

  AST_READ_BEATS: assert property (@(posedge mclk) disable iff (sys_rst || !dramResetN)
    rwGo && cmdCode == CMD_RD && !bc4Sel |-> ##1 dqOeN ##1 !dqOeN[*4] ##1 dqOeN)
    else $error("Full read did not drive four clocks of beats.");

  AST_CHOP_BEATS: assert property (@(posedge mclk) disable iff (sys_rst || !dramResetN)
    rwGo && cmdCode == CMD_RD && bc4Sel |-> ##2 !dqOeN[*2] ##1 dqOeN)
    else $error("Chopped read did not drive two clocks of beats.");

  AST_ACT_OPENS: assert property (@(posedge mclk) disable iff (sys_rst || !dramResetN)
    accept && cmdCode == CMD_ACT && !openReg[reqIdx]
    |=> openReg[$past(reqIdx)] && rowReg[$past(reqIdx)] == $past(addr[ROW_BITS-1:0]))
    else $error("Activate did not open the addressed row.");

  AST_START_COL: assert property (@(posedge mclk) disable iff (sys_rst || !dramResetN)
    rwGo |=> colReg == $past(addr[COL_BITS-1:0]) && seqBus.colRise == $past(addr[2:0]))
    else $error("Burst did not start at the given column.");

  AST_AUTO_PRE: assert property (@(posedge mclk) disable iff (sys_rst || !dramResetN)
    rwGo && addr[AP_BIT] && !bc4Sel |-> ##4 openReg[curBankReg] ##1 !openReg[curBankReg])
    else $error("Auto precharge did not close the bank at burst end.");

  AST_OTF_SELECT: assert property (@(posedge mclk) disable iff (sys_rst || !dramResetN)
    rwGo && modeBurst == BURST_OTF |-> ##2 (seqBus.last == !$past(addr[BC_BIT], 2)))
    else $error("On-the-fly bit did not choose the burst length.");
endmodule // ddr4_core

// ---- sim/dram_ctrl_model.sv ----
// Purpose: Behavioural memory controller that drives the command, address and write-data pins of the core.
// Assumes: Caller enters each task just after a rising mclk edge.
// Notes: WAIT_CYC stands in for the long post-reset settling wait so that runs stay short.
`timescale 1ns/1ps
module dram_ctrl_model #(
  parameter int DQ_WIDTH = 8,
  parameter int WAIT_CYC = 20
) (
  input wire logic mclk,
  output logic dramResetN,
  output logic cmdValid,
  output ddr4_core_pkg::cmd_t cmdCode,
  output logic [1:0] bankGroup,
  output logic [1:0] bankAddr,
  output logic [ddr4_core_pkg::ADDR_BITS-1:0] addr,
  output logic [DQ_WIDTH-1:0] dqInRise,
  output logic [DQ_WIDTH-1:0] dqInFall
);
  import ddr4_core_pkg::*;
  logic strict;
  logic [MAX_BANKS-1:0] opened;

  // The reset pin idles high; the bank mirror starts empty.
  initial begin
    dramResetN = 1'b1;
    cmdValid = 1'b0;
    cmdCode = CMD_NOP;
    bankGroup = 2'h0;
    bankAddr = 2'h0;
    addr = '0;
    dqInRise = '0;
    dqInFall = '0;
    strict = 1'b1;
    opened = '0;
  end

  // Pulses reset, then waits before any access, since the array settles on its own.
  task automatic powerUp();
    dramResetN = 1'b0;
    opened = '0;
    @(posedge mclk);
    #1 dramResetN = 1'b1;
    repeat (WAIT_CYC) @(posedge mclk);
    #1;
  endtask

  // Presents one command for one edge; in strict mode it never reads or writes a closed bank.
  task automatic issue(input cmd_t c, input logic [1:0] g, input logic [1:0] b, input logic [ADDR_BITS-1:0] a);
    if (strict && (c == CMD_RD || c == CMD_WR) && !opened[{g, b}]) return;
    cmdValid = 1'b1;
    cmdCode = c;
    bankGroup = g;
    bankAddr = b;
    addr = a;
    @(posedge mclk);
    #1 cmdValid = 1'b0;
    cmdCode = CMD_NOP;
    addr = ~a; // A released bus must not keep showing the old value.
    if (c == CMD_ACT) opened[{g, b}] = 1'b1;
    if (c == CMD_PRE && a[AP_BIT]) opened = '0;
    else if (c == CMD_PRE || ((c == CMD_RD || c == CMD_WR) && a[AP_BIT])) opened[{g, b}] = 1'b0;
  endtask

  // Places one even and one odd write beat for the current clock.
  task automatic putPair(input logic [DQ_WIDTH-1:0] r, input logic [DQ_WIDTH-1:0] f);
    dqInRise = r;
    dqInFall = f;
  endtask
endmodule // dram_ctrl_model

// ---- sim/tb_top.sv ----
// Purpose: Self-checking bench for the bank, row and burst datapath.
// Assumes: x8 build; write data is a known pattern per column.
// Notes: Bank commands run from a table; bursts, refusals and reset are written out by hand.
`timescale 1ns/1ps
module tb_top;
  import ddr4_core_pkg::*;
  typedef struct {cmd_t c; logic [1:0] g; logic [1:0] b; logic [17:0] a; logic err; logic [15:0] open;} row_t;
  logic mclk, sysRst, dramResetN, cmdValid, modeInterleave, cmdReady, cmdErr, dqOeN;
  cmd_t cmdCode;
  logic [1:0] bankGroup, bankAddr, modeBurst;
  logic [17:0] addr;
  logic [7:0] dqInRise, dqInFall, dqRise, dqFall;
  logic [15:0] bankOpen;
  logic [7:0] pat [8];
  int miscompares = 0;
  int comparisons = 0;
  // Each row is one command and the open mask and error it must leave one cycle later.
  row_t rows [7] = '{'{CMD_ACT, 2'h0, 2'h0, 18'h00000, 1'b0, 16'h0001},
    '{CMD_ACT, 2'h3, 2'h3, 18'h0FFFF, 1'b0, 16'h8001}, '{CMD_ACT, 2'h0, 2'h0, 18'h00000, 1'b1, 16'h8001},
    '{CMD_PRE, 2'h3, 2'h3, 18'h00000, 1'b0, 16'h0001}, '{CMD_ACT, 2'h2, 2'h1, 18'h0A5A5, 1'b0, 16'h0201},
    '{CMD_PRE, 2'h0, 2'h0, 18'h00400, 1'b0, 16'h0000}, '{CMD_ACT, 2'h1, 2'h2, 18'h00000, 1'b0, 16'h0040}};

  ddr4_core #(.DQ_WIDTH(8), .ROW_KEEP(2)) u_dut (.mclk(mclk), .sys_rst(sysRst), .dramResetN(dramResetN),
    .cmdValid(cmdValid), .cmdCode(cmdCode), .bankGroup(bankGroup), .bankAddr(bankAddr), .addr(addr),
    .modeBurst(modeBurst), .modeInterleave(modeInterleave), .dqInRise(dqInRise), .dqInFall(dqInFall),
    .cmdReady(cmdReady), .cmdErr(cmdErr), .dqRise(dqRise), .dqFall(dqFall), .dqOeN(dqOeN), .bankOpen(bankOpen));
  dram_ctrl_model #(.DQ_WIDTH(8), .WAIT_CYC(20)) u_ctl (.mclk(mclk), .dramResetN(dramResetN),
    .cmdValid(cmdValid), .cmdCode(cmdCode), .bankGroup(bankGroup), .bankAddr(bankAddr), .addr(addr),
    .dqInRise(dqInRise), .dqInFall(dqInFall));

  // Free-running 250 MHz clock.
  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  // Column low bits of beat k; kept separate from the design's own helper on purpose.
  function automatic logic [2:0] colOf(input logic [2:0] s, input logic [2:0] k, input logic ilv);
    return ilv ? (s ^ k) : {s[2] ^ k[2], s[1:0] + k[1:0]};
  endfunction

  // Lets one edge pass, waits for ready under a bound, then hands the command to the controller.
  task automatic cmd(input cmd_t c, input logic [1:0] g, input logic [1:0] b, input logic [17:0] a);
    int n;
    n = 0;
    @(posedge mclk);
    #1;
    while (cmdReady !== 1'b1) begin
      n++;
      if (n > 20) begin
        miscompares++;
        $display("ERROR %0t ready timeout", $time);
        stop_test();
      end
      @(posedge mclk);
      #1;
    end
    u_ctl.issue(c, g, b, a);
  endtask

  // One burst: drives write pairs or checks read pairs, busy time, ready and auto precharge.
  task automatic xfer(input cmd_t c, input logic [3:0] bk, input logic [17:0] a, input int pairs);
    logic [2:0] s;
    s = a[2:0];
    cmd(c, bk[3:2], bk[1:0], a);
    for (int cyc = 1; cyc <= pairs + 2; cyc++) begin
      if (c == CMD_WR && cyc <= pairs)
        u_ctl.putPair(pat[colOf(s, 3'(2 * cyc - 2), modeInterleave)], pat[colOf(s, 3'(2 * cyc - 1), modeInterleave)]);
      if (c == CMD_RD && cyc >= 2 && cyc <= pairs + 1)
        chk(dqOeN === 1'b0 && dqRise === pat[colOf(s, 3'(2 * cyc - 4), modeInterleave)]
          && dqFall === pat[colOf(s, 3'(2 * cyc - 3), modeInterleave)], "read pair");
      if (cyc == pairs) chk(cmdReady === 1'b0, "busy");
      if (cyc == pairs + 1) chk(cmdReady === 1'b1 && bankOpen[bk] === !a[AP_BIT], "burst end");
      if (c == CMD_RD && cyc == pairs + 2) chk(dqOeN === 1'b1, "read end");
      @(posedge mclk);
      #1;
    end
  endtask

  // Bounded run length.
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    $display("ERROR %0t watchdog", $time);
    stop_test();
  end

  initial begin
    sysRst = 1'b1;
    modeBurst = BURST_BL8;
    modeInterleave = 1'b0;
    for (int j = 0; j < 8; j++) pat[j] = 8'h10 + 8'(j);
    repeat (3) @(posedge mclk);
    #1 sysRst = 1'b0;
    chk(cmdReady === 1'b1 && bankOpen === 16'h0000 && dqOeN === 1'b1 && cmdErr === 1'b0, "reset");
    u_ctl.powerUp();
    foreach (rows[i]) begin
      cmd(rows[i].c, rows[i].g, rows[i].b, rows[i].a);
      chk(cmdErr === rows[i].err && bankOpen === rows[i].open, "bank command");
    end
    // Write in interleave order from column 3, read back in both orders.
    modeInterleave = 1'b1;
    xfer(CMD_WR, 4'h6, 18'h00003, 4);
    xfer(CMD_RD, 4'h6, 18'h00005, 4);
    modeInterleave = 1'b0;
    xfer(CMD_RD, 4'h6, 18'h00006, 4);
    modeBurst = BURST_BC4;
    xfer(CMD_RD, 4'h6, 18'h00002, 2);
    modeBurst = BURST_OTF;
    xfer(CMD_RD, 4'h6, 18'h00001, 2);
    xfer(CMD_RD, 4'h6, 18'h01004, 4);
    modeBurst = BURST_BL8;
    xfer(CMD_RD, 4'h6, 18'h00400, 4);
    // A read to a closed bank is refused with an error and drives nothing.
    u_ctl.strict = 1'b0;
    cmd(CMD_RD, 2'h1, 2'h2, 18'h00000);
    chk(cmdErr === 1'b1 && bankOpen === 16'h0000, "closed bank");
    @(posedge mclk);
    #1 chk(dqOeN === 1'b1, "no data");
    u_ctl.strict = 1'b1;
    // A command presented while a burst runs is dropped and flagged.
    cmd(CMD_ACT, 2'h1, 2'h2, 18'h00000);
    cmd(CMD_RD, 2'h1, 2'h2, 18'h00000);
    @(posedge mclk);
    #1 u_ctl.issue(CMD_PRE, 2'h1, 2'h2, 18'h00000);
    chk(cmdErr === 1'b1 && bankOpen[6] === 1'b1 && dqOeN === 1'b0, "busy refusal");
    // The refused precharge left bank 6 open, so the controller's mirror must say so too.
    u_ctl.opened[6] = 1'b1;
    // The array reset acts mid-burst without waiting for a clock edge.
    repeat (4) @(posedge mclk);
    cmd(CMD_RD, 2'h1, 2'h2, 18'h00000);
    @(posedge mclk);
    #1 chk(dqOeN === 1'b0, "burst running");
    fork
      u_ctl.powerUp();
      #1 chk(dqOeN === 1'b1 && bankOpen === 16'h0000 && cmdReady === 1'b1, "async reset");
    join
    stop_test();
  end
endmodule // tb_top
